// >>> inc/pwr_mode_pkg.sv
// package: register map, field layout, wake sources and modes of the low-power controller
package pwr_mode_pkg;

	// register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_CLOCK_CONTROL_0 = 8'h00;
	localparam logic [7:0] OFS_CLOCK_CONTROL_1 = 8'h04;
	localparam logic [7:0] OFS_PLL_CTRL        = 8'h08;
	localparam logic [7:0] OFS_OSC_DETECT      = 8'h0C;
	localparam logic [7:0] OFS_STATUS          = 8'h10;

	// clock_control_0 fields
	localparam int CC0_PCLK_STOP_BIT  = 0;
	localparam int CC0_DIV8_BIT       = 1;
	localparam int CC0_CLOCK_OUTPUT_PIN_MAIN    = 2;
	localparam int CC0_SRC_LSB        = 3;
	// clock_control_1 fields
	localparam int CC1_ALL_OFF_BIT    = 0;
	localparam int CC1_PLL_CPU_BIT    = 1;
	localparam int CC1_DRIVE_HIGH_BIT = 2;
	// pll and oscillator-detect fields
	localparam int PLL_EN_BIT         = 0;
	localparam int OSC_DET_BIT        = 0;
	// status fields
	localparam int ST_MODE_LSB        = 0;
	localparam int ST_WAKE_NMI_BIT    = 4;
	localparam int ST_WAKE_IRQ_BIT    = 5;

	// reset values
	localparam logic       RST_PCLK_STOP  = 1'b0;
	localparam logic       RST_DIV8       = 1'b1;
	localparam logic       RST_CLOCK_OUTPUT_PIN_MAIN = 1'b0;
	localparam logic       RST_PLL_CPU    = 1'b0;
	localparam logic       RST_DRIVE_HIGH = 1'b1;
	localparam logic       RST_PLL_EN     = 1'b0;
	localparam logic       RST_OSC_DET    = 1'b0;
	localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

	// width of the general-purpose i/o port image
	localparam int IO_W = 16;

	// priority field value that disables an interrupt
	localparam logic [2:0] PRIO_OFF = 3'h0;

	// wake source indices
	localparam int SRC_SERIAL = 0;
	localparam int SRC_I2C    = 1;
	localparam int SRC_KEY    = 2;
	localparam int SRC_CONV   = 3;
	localparam int SRC_TIMAB  = 4;
	localparam int SRC_TIMS   = 5;
	localparam int SRC_INT    = 6;
	localparam int SRC_CANWK  = 7;
	localparam int SRC_LVD    = 8;
	localparam int NSRC       = 9;

	// cpu clock source selection
	typedef enum logic [1:0] {
		CLK_MAIN     = 2'b00,
		CLK_SUB      = 2'b01,
		CLK_INTERNAL = 2'b10
	} cpu_src_e;

	// power mode
	typedef enum logic [1:0] {
		MODE_RUN  = 2'b00,
		MODE_WAIT = 2'b01,
		MODE_STOP = 2'b10
	} pwr_mode_e;

	// operating condition of each peripheral that may wake the device
	typedef struct packed {
		logic serial_ext_clk;   // serial unit clocked from its pin
		logic timer_event_mode; // timer a/b counting external pulses
		logic timer_src_div32;  // timer a/b counting subclock_div32
		logic conv_single;      // converter in one-shot or single-sweep
		logic can_sleep;        // bus controller in its sleep mode
	} periph_qual_s;

	// clock enables handed to the clock generator
	typedef struct packed {
		logic osc_en;          // all oscillators
		logic cpu_clk_en;      // cpu clock
		logic periph_clk_en;   // divided peripheral, serial, converter clocks
		logic subclock_div32_en; // 32-divided sub clock
	} clk_en_s;

endpackage

// >>> src/pin_hold.sv
// pin state freeze: passes live values, holds the last one while hold is asserted
`timescale 1ns/1ps
module pin_hold #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// control
	input  wire logic             hold_i,
	// data
	input  wire logic [WIDTH-1:0] live_i,
	output logic      [WIDTH-1:0] pin_o
);

	// output flop follows live data, freezes while held
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_o <= '0;
		end else if (!hold_i) begin
			pin_o <= live_i;
		end
	end

endmodule

// >>> src/pwr_mode_ctrl.sv
// wait and stop low-power mode controller with its control registers
`timescale 1ns/1ps
module pwr_mode_ctrl (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_n_i,
	// register port
	input  wire logic [7:0]                   addr_i,
	input  wire logic [31:0]                  wdata_i,
	input  wire logic                         wr_i,
	input  wire logic                         rd_i,
	output logic      [31:0]                  rdata_o,
	// cpu side
	input  wire logic                         wait_instr_i,
	input  wire logic                         i_flag_i,
	input  wire logic                         nmi_n_i,
	// on-chip interrupt sources
	input  wire logic [pwr_mode_pkg::NSRC-1:0] irq_req_i,
	input  wire logic [pwr_mode_pkg::NSRC-1:0][2:0] irq_prio_i,
	input  wire pwr_mode_pkg::periph_qual_s   qual_i,
	// clock sources seen by the clock output pin
	input  wire logic                         subclock_source_i,
	input  wire logic                         main_div_clk_i,
	// port image from the i/o registers
	input  wire logic [pwr_mode_pkg::IO_W-1:0] io_level_i,
	input  wire logic [pwr_mode_pkg::IO_W-1:0] io_dir_i,
	// pins and clock controls
	output logic      [pwr_mode_pkg::IO_W-1:0] io_level_o,
	output logic      [pwr_mode_pkg::IO_W-1:0] io_dir_o,
	output logic                              clock_output_pin_o,
	output pwr_mode_pkg::clk_en_s             clk_en_o,
	output pwr_mode_pkg::cpu_src_e            cpu_src_o,
	output logic                              cpu_div8_select_o,
	output logic                              main_osc_drive_high_o,
	output logic                              pll_cpu_select_o,
	output logic                              pll_enable_o,
	output logic                              osc_stop_detect_enable_o,
	output logic                              wake_service_o
);

	// control and status state
	pwr_mode_pkg::pwr_mode_e mode_q;             // current power mode
	pwr_mode_pkg::cpu_src_e  cpu_src_q;          // cpu clock source
	logic                    pclk_stop_q;        // peripheral_clk_stop_in_wait
	logic                    div8_q;             // cpu_div8_select
	logic                    clock_output_pin_main_q;      // clock output takes divided main clock
	logic                    all_off_q;          // all_clocks_off
	logic                    pll_cpu_q;          // pll_cpu_select
	logic                    drive_high_q;       // main_osc_drive_high
	logic                    pll_en_q;           // pll_enable
	logic                    osc_det_q;          // osc_stop_detect_enable
	logic                    wake_nmi_q;         // last wake came from nmi
	logic                    wake_irq_q;         // last wake came from a peripheral
	logic                    clock_output_pin_q;           // clock output pin flop
	logic                    service_q;          // service request after wake
	logic [31:0]             rdata_q;            // read data, one cycle late

	// nmi pin synchroniser and edge detect
	logic nmi_s1_q;   // first stage, read only by the second
	logic nmi_s2_q;   // second stage
	logic nmi_s3_q;   // previous value for edge detect
	logic nmi_evt;    // falling edge on the pin

	// wake qualification
	logic [pwr_mode_pkg::NSRC-1:0] prio_on;  // priority field nonzero
	logic [pwr_mode_pkg::NSRC-1:0] ok_wait;  // source usable from wait
	logic [pwr_mode_pkg::NSRC-1:0] ok_stop;  // source usable from stop
	logic                          wake_wait;
	logic                          wake_stop;
	logic                          in_low;   // wait or stop
	logic                          stop_write; // software sets all_clocks_off

	// write decode helpers
	logic wr_cc0;
	logic wr_cc1;
	logic wr_pll;
	logic wr_osc;

	// nmi synchroniser: two flops before any logic looks at the pin
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nmi_s1_q <= 1'b1;
			nmi_s2_q <= 1'b1;
			nmi_s3_q <= 1'b1;
		end else begin
			nmi_s1_q <= nmi_n_i;
			nmi_s2_q <= nmi_s1_q;
			nmi_s3_q <= nmi_s2_q;
		end
	end

	// the pin is active low, so the event is the falling edge
	assign nmi_evt = nmi_s3_q && !nmi_s2_q;

	// address decode for writes
	always_comb begin
		wr_cc0 = 1'b0;
		wr_cc1 = 1'b0;
		wr_pll = 1'b0;
		wr_osc = 1'b0;
		if (wr_i && addr_i == pwr_mode_pkg::OFS_CLOCK_CONTROL_0) begin
			wr_cc0 = 1'b1;
		end else if (wr_i && addr_i == pwr_mode_pkg::OFS_CLOCK_CONTROL_1) begin
			wr_cc1 = 1'b1;
		end else if (wr_i && addr_i == pwr_mode_pkg::OFS_PLL_CTRL) begin
			wr_pll = 1'b1;
		end else if (wr_i && addr_i == pwr_mode_pkg::OFS_OSC_DETECT) begin
			wr_osc = 1'b1;
		end
	end

	// stop is entered by the write itself, while the cpu still runs
	assign stop_write = wr_cc1 && wdata_i[pwr_mode_pkg::CC1_ALL_OFF_BIT]
		&& mode_q == pwr_mode_pkg::MODE_RUN;
	assign in_low = mode_q != pwr_mode_pkg::MODE_RUN;

	// a zero priority field disables the source outright
	always_comb begin
		for (int i = 0; i < pwr_mode_pkg::NSRC; i++) begin
			prio_on[i] = irq_prio_i[i] != pwr_mode_pkg::PRIO_OFF;
		end
	end

	// sources that may wake from wait, per peripheral clock setting
	always_comb begin
		ok_wait = '1;
		// converter only counts in its single-run modes while clocks run
		ok_wait[pwr_mode_pkg::SRC_CONV] = qual_i.conv_single && !pclk_stop_q;
		// bus controller wake only while it sleeps, in either setting
		ok_wait[pwr_mode_pkg::SRC_CANWK] = qual_i.can_sleep;
		if (pclk_stop_q) begin
			// internal clocks are gone: keep only units driven from their pins or from subclock_div32
			ok_wait[pwr_mode_pkg::SRC_SERIAL] = qual_i.serial_ext_clk;
			ok_wait[pwr_mode_pkg::SRC_TIMAB]  = qual_i.timer_event_mode
				|| qual_i.timer_src_div32;
			ok_wait[pwr_mode_pkg::SRC_I2C]    = 1'b0;
			ok_wait[pwr_mode_pkg::SRC_TIMS]   = 1'b0;
		end
	end

	// sources that may wake from stop: only those running without oscillators
	always_comb begin
		ok_stop = '0;
		ok_stop[pwr_mode_pkg::SRC_KEY]    = 1'b1;
		ok_stop[pwr_mode_pkg::SRC_INT]    = 1'b1;
		ok_stop[pwr_mode_pkg::SRC_LVD]    = 1'b1;
		ok_stop[pwr_mode_pkg::SRC_TIMAB]  = qual_i.timer_event_mode;
		ok_stop[pwr_mode_pkg::SRC_SERIAL] = qual_i.serial_ext_clk;
		ok_stop[pwr_mode_pkg::SRC_CANWK]  = qual_i.can_sleep;
	end

	// wake decisions; reset needs no term here, it clears the mode directly
	assign wake_wait = nmi_evt || |(irq_req_i & prio_on & ok_wait);
	assign wake_stop = nmi_evt || |(irq_req_i & prio_on & ok_stop);

	// power mode sequencer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= pwr_mode_pkg::MODE_RUN;
		end else begin
			case (mode_q)
				pwr_mode_pkg::MODE_RUN: begin
					// the register write wins over a wait issued alongside it
					if (stop_write) begin
						mode_q <= pwr_mode_pkg::MODE_STOP;
					end else if (wait_instr_i) begin
						mode_q <= pwr_mode_pkg::MODE_WAIT;
					end
				end
				pwr_mode_pkg::MODE_WAIT: begin
					if (wake_wait) begin
						mode_q <= pwr_mode_pkg::MODE_RUN;
					end
				end
				pwr_mode_pkg::MODE_STOP: begin
					if (wake_stop) begin
						mode_q <= pwr_mode_pkg::MODE_RUN;
					end
				end
				default: begin
					mode_q <= pwr_mode_pkg::MODE_RUN;
				end
			endcase
		end
	end

	// wake cause flags, refreshed on every wake
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_nmi_q <= 1'b0;
			wake_irq_q <= 1'b0;
		end else if ((mode_q == pwr_mode_pkg::MODE_WAIT && wake_wait)
			|| (mode_q == pwr_mode_pkg::MODE_STOP && wake_stop)) begin
			wake_nmi_q <= nmi_evt;
			wake_irq_q <= !nmi_evt;
		end
	end

	// service request one cycle after a peripheral wake, once the cpu clocks;
	// the routine runs only if software left the global flag set
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			service_q <= 1'b0;
		end else begin
			service_q <= i_flag_i && !nmi_evt
				&& ((mode_q == pwr_mode_pkg::MODE_WAIT && wake_wait)
				|| (mode_q == pwr_mode_pkg::MODE_STOP && wake_stop));
		end
	end

	// clock_control_0; wait leaves the cpu selection untouched so it resumes as is
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pclk_stop_q   <= pwr_mode_pkg::RST_PCLK_STOP;
			div8_q        <= pwr_mode_pkg::RST_DIV8;
			clock_output_pin_main_q <= pwr_mode_pkg::RST_CLOCK_OUTPUT_PIN_MAIN;
			cpu_src_q     <= pwr_mode_pkg::CLK_MAIN;
		end else if (stop_write) begin
			// forced in the same cycle as the stop entry; sub clock ignores it
			div8_q <= 1'b1;
		end else if (wr_cc0 && !in_low) begin
			pclk_stop_q   <= wdata_i[pwr_mode_pkg::CC0_PCLK_STOP_BIT];
			div8_q        <= wdata_i[pwr_mode_pkg::CC0_DIV8_BIT];
			clock_output_pin_main_q <= wdata_i[pwr_mode_pkg::CC0_CLOCK_OUTPUT_PIN_MAIN];
			cpu_src_q     <= pwr_mode_pkg::cpu_src_e'(
				wdata_i[pwr_mode_pkg::CC0_SRC_LSB +: 2]);
		end
	end

	// clock_control_1; all_clocks_off stands for the whole stop and drops on wake
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			all_off_q    <= 1'b0;
			pll_cpu_q    <= pwr_mode_pkg::RST_PLL_CPU;
			drive_high_q <= pwr_mode_pkg::RST_DRIVE_HIGH;
		end else if (mode_q == pwr_mode_pkg::MODE_STOP) begin
			all_off_q <= !wake_stop;
		end else if (wr_cc1 && !in_low) begin
			all_off_q    <= wdata_i[pwr_mode_pkg::CC1_ALL_OFF_BIT];
			pll_cpu_q    <= wdata_i[pwr_mode_pkg::CC1_PLL_CPU_BIT];
			// writing stop forces high drive whatever the written value
			drive_high_q <= wdata_i[pwr_mode_pkg::CC1_DRIVE_HIGH_BIT]
				|| wdata_i[pwr_mode_pkg::CC1_ALL_OFF_BIT];
		end
	end

	// pll and oscillator-detect enables; software must clear both before
	// stop, nothing here overrides a careless setting
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pll_en_q  <= pwr_mode_pkg::RST_PLL_EN;
			osc_det_q <= pwr_mode_pkg::RST_OSC_DET;
		end else begin
			if (wr_pll && !in_low) begin
				pll_en_q <= wdata_i[pwr_mode_pkg::PLL_EN_BIT];
			end
			if (wr_osc && !in_low) begin
				osc_det_q <= wdata_i[pwr_mode_pkg::OSC_DET_BIT];
			end
		end
	end

	// clock output pin: sub clock always toggles in wait; main-divided freezes
	// in wait when peripheral clocks stop; everything freezes in stop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clock_output_pin_q <= 1'b0;
		end else if (mode_q == pwr_mode_pkg::MODE_STOP) begin
			clock_output_pin_q <= clock_output_pin_q;
		end else if (mode_q == pwr_mode_pkg::MODE_WAIT && clock_output_pin_main_q && pclk_stop_q) begin
			clock_output_pin_q <= clock_output_pin_q;
		end else if (clock_output_pin_main_q) begin
			clock_output_pin_q <= main_div_clk_i;
		end else begin
			clock_output_pin_q <= subclock_source_i;
		end
	end

	// clock enables follow the mode directly so they drop on the entry edge
	always_comb begin
		clk_en_o.osc_en            = mode_q != pwr_mode_pkg::MODE_STOP;
		clk_en_o.cpu_clk_en        = mode_q == pwr_mode_pkg::MODE_RUN;
		clk_en_o.periph_clk_en     = mode_q == pwr_mode_pkg::MODE_RUN
			|| (mode_q == pwr_mode_pkg::MODE_WAIT && !pclk_stop_q);
		clk_en_o.subclock_div32_en = mode_q != pwr_mode_pkg::MODE_STOP;
	end

	// i/o retention: level and direction frozen through wait and stop
	pin_hold #(
		.WIDTH (pwr_mode_pkg::IO_W)
	) u_level_hold (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.hold_i  (in_low),
		.live_i  (io_level_i),
		.pin_o   (io_level_o)
	);

	pin_hold #(
		.WIDTH (pwr_mode_pkg::IO_W)
	) u_dir_hold (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.hold_i  (in_low),
		.live_i  (io_dir_i),
		.pin_o   (io_dir_o)
	);

	// read data register; unmapped addresses read zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= pwr_mode_pkg::RD_ZERO;
		end else if (!rd_i) begin
			rdata_q <= pwr_mode_pkg::RD_ZERO;
		end else if (addr_i == pwr_mode_pkg::OFS_CLOCK_CONTROL_0) begin
			rdata_q <= pwr_mode_pkg::RD_ZERO;
			rdata_q[pwr_mode_pkg::CC0_PCLK_STOP_BIT] <= pclk_stop_q;
			rdata_q[pwr_mode_pkg::CC0_DIV8_BIT]      <= div8_q;
			rdata_q[pwr_mode_pkg::CC0_CLOCK_OUTPUT_PIN_MAIN]   <= clock_output_pin_main_q;
			rdata_q[pwr_mode_pkg::CC0_SRC_LSB +: 2]  <= cpu_src_q;
		end else if (addr_i == pwr_mode_pkg::OFS_CLOCK_CONTROL_1) begin
			rdata_q <= pwr_mode_pkg::RD_ZERO;
			rdata_q[pwr_mode_pkg::CC1_ALL_OFF_BIT]    <= all_off_q;
			rdata_q[pwr_mode_pkg::CC1_PLL_CPU_BIT]    <= pll_cpu_q;
			rdata_q[pwr_mode_pkg::CC1_DRIVE_HIGH_BIT] <= drive_high_q;
		end else if (addr_i == pwr_mode_pkg::OFS_PLL_CTRL) begin
			rdata_q <= pwr_mode_pkg::RD_ZERO;
			rdata_q[pwr_mode_pkg::PLL_EN_BIT] <= pll_en_q;
		end else if (addr_i == pwr_mode_pkg::OFS_OSC_DETECT) begin
			rdata_q <= pwr_mode_pkg::RD_ZERO;
			rdata_q[pwr_mode_pkg::OSC_DET_BIT] <= osc_det_q;
		end else if (addr_i == pwr_mode_pkg::OFS_STATUS) begin
			rdata_q <= pwr_mode_pkg::RD_ZERO;
			rdata_q[pwr_mode_pkg::ST_MODE_LSB +: 2]  <= mode_q;
			rdata_q[pwr_mode_pkg::ST_WAKE_NMI_BIT]   <= wake_nmi_q;
			rdata_q[pwr_mode_pkg::ST_WAKE_IRQ_BIT]   <= wake_irq_q;
		end else begin
			rdata_q <= pwr_mode_pkg::RD_ZERO;
		end
	end

	// outputs
	assign rdata_o                  = rdata_q;
	assign clock_output_pin_o       = clock_output_pin_q;
	assign cpu_src_o                = cpu_src_q;  // kept across wake
	assign cpu_div8_select_o        = div8_q;
	assign main_osc_drive_high_o    = drive_high_q;
	assign pll_cpu_select_o         = pll_cpu_q;
	assign pll_enable_o             = pll_en_q;
	assign osc_stop_detect_enable_o = osc_det_q;
	assign wake_service_o           = service_q;

endmodule

// >>> tb/irq_src_model.sv
// partner model: software priority setup and on-chip interrupt sources
`timescale 1ns/1ps
module irq_src_model (
	// clock and reset
	input	wire logic					clk_i,
	input	wire logic					rst_n_i,
	// scenario control
	input	wire logic [pwr_mode_pkg::NSRC-1:0]		arm_i,
	input	wire logic [pwr_mode_pkg::NSRC-1:0]		fire_i,
	// toward the controller
	output	logic [pwr_mode_pkg::NSRC-1:0]			irq_req_o,
	output	logic [pwr_mode_pkg::NSRC-1:0][2:0]		irq_prio_o,
	output	logic						sub_clk_o,
	output	logic						div_clk_o
);
	logic [1:0]	div_q;	// slow divider for the main-derived clock

	// armed sources get a level, every other field is zeroed
	always_comb begin
		for (int i = 0; i < pwr_mode_pkg::NSRC; i++) begin
			irq_prio_o[i] = arm_i[i] ? 3'h3 : pwr_mode_pkg::PRIO_OFF;
		end
	end

	// flags rise a cycle after the event, like a real peripheral
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_req_o <= '0;
		end else begin
			irq_req_o <= fire_i;
		end
	end

	// sub clock toggles every cycle, divided main every two
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sub_clk_o <= 1'b0;
			div_q <= 2'h0;
		end else begin
			sub_clk_o <= ~sub_clk_o;
			div_q <= div_q + 2'h1;
		end
	end
	assign div_clk_o = div_q[1];
endmodule

// >>> tb/pwr_mode_props.sv
// checker: port-level properties of the low-power mode controller
`timescale 1ns/1ps
module pwr_mode_props (
	// clock, reset and requests
	input	wire logic					clk_i,
	input	wire logic					rst_n_i,
	input	wire logic [7:0]				addr_i,
	input	wire logic [31:0]				wdata_i,
	input	wire logic					wr_i,
	input	wire logic					wait_instr_i,
	input	wire logic					i_flag_i,
	input	wire logic					nmi_n_i,
	input	wire logic [pwr_mode_pkg::NSRC-1:0]		irq_req_i,
	input	wire logic [pwr_mode_pkg::NSRC-1:0][2:0]	irq_prio_i,
	// outputs watched
	input	wire logic [pwr_mode_pkg::IO_W-1:0]		io_level_o,
	input	wire logic [pwr_mode_pkg::IO_W-1:0]		io_dir_o,
	input	wire pwr_mode_pkg::clk_en_s			clk_en_o,
	input	wire pwr_mode_pkg::cpu_src_e			cpu_src_o,
	input	wire logic					cpu_div8_select_o,
	input	wire logic					main_osc_drive_high_o,
	input	wire logic					wake_service_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic		run, waitm, stopm, key_ok, nmi_quiet;	// mode seen through clock enables
	logic [3:0]	nmi_q;					// recent nmi pin samples
	assign run = clk_en_o.osc_en & clk_en_o.cpu_clk_en;
	assign waitm = clk_en_o.osc_en & ~clk_en_o.cpu_clk_en;
	assign stopm = ~clk_en_o.osc_en;
	assign key_ok = irq_req_i[pwr_mode_pkg::SRC_KEY] & (|irq_prio_i[pwr_mode_pkg::SRC_KEY]);
	// the pin is synced, so a fall only counts a few edges late
	assign nmi_quiet = nmi_n_i & (&nmi_q);

	// nmi history for the quiet-pin condition
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nmi_q <= 4'hF;
		end else begin
			nmi_q <= {nmi_q[2:0], nmi_n_i};
		end
	end

	sequence s_stop_wr;
		run && wr_i && addr_i == pwr_mode_pkg::OFS_CLOCK_CONTROL_1 && wdata_i[0];
	endsequence
	sequence s_stop_exit;
		stopm ##1 run;
	endsequence

	property p_stop_entry;
		s_stop_wr |=> clk_en_o == 4'h0 && cpu_div8_select_o && main_osc_drive_high_o;
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop entry wrong");
	property p_wait_entry;
		run && wait_instr_i && !wr_i |=> waitm && clk_en_o.subclock_div32_en;
	endproperty
	a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");
	property p_hold;
		!run && !$past(run) |-> $stable(io_level_o) && $stable(io_dir_o);
	endproperty
	a_hold: assert property (p_hold) else $error("pins moved in low power");
	property p_wait_src;
		waitm |=> $stable(cpu_src_o);
	endproperty
	a_wait_src: assert property (p_wait_src) else $error("cpu clock changed in wait");
	property p_stop_div8;
		s_stop_exit |-> cpu_div8_select_o;
	endproperty
	a_stop_div8: assert property (p_stop_div8) else $error("stop exit not div8");
	property p_quiet_wait;
		waitm && irq_prio_i == '0 && nmi_quiet |=> waitm;
	endproperty
	a_quiet_wait: assert property (p_quiet_wait) else $error("wait left without cause");
	property p_quiet_stop;
		stopm && irq_prio_i == '0 && nmi_quiet |=> stopm;
	endproperty
	a_quiet_stop: assert property (p_quiet_stop) else $error("stop left without cause");
	property p_irq_wake;
		!run && key_ok && i_flag_i && nmi_quiet |=> run && wake_service_o;
	endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("key wake failed");
endmodule

bind pwr_mode_ctrl pwr_mode_props PROPS (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
	.wait_instr_i, .i_flag_i, .nmi_n_i, .irq_req_i, .irq_prio_i, .io_level_o, .io_dir_o,
	.clk_en_o, .cpu_src_o, .cpu_div8_select_o, .main_osc_drive_high_o, .wake_service_o);

// >>> tb/pwr_mode_ctrl_tb.sv
// testbench: directed scenarios for the low-power mode controller
`timescale 1ns/1ps
module pwr_mode_ctrl_tb;
	logic				clk_i, rst_n_i, wr, rd, wait_i, iflag, nmi_n;	// drives
	logic				subc, divc, clock_output_pin, div8, drive, svc;		// observed bits
	logic [7:0]			addr;
	logic [31:0]			wdata, rdata;
	logic [15:0]			io_lv, io_o, io_d;
	logic [pwr_mode_pkg::NSRC-1:0]	arm, fire, req;
	logic [pwr_mode_pkg::NSRC-1:0][2:0]	prio;
	pwr_mode_pkg::periph_qual_s	qual;
	pwr_mode_pkg::clk_en_s		clk_en;
	pwr_mode_pkg::cpu_src_e		cpu_src;
	int				num_errors, checks;

	logic				pllc, plle, oscd;	// pll select, pll enable and detector enable
	pwr_mode_ctrl DUT (.clk_i, .rst_n_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .wait_instr_i(wait_i), .i_flag_i(iflag), .nmi_n_i(nmi_n),
		.irq_req_i(req), .irq_prio_i(prio), .qual_i(qual), .subclock_source_i(subc),
		.main_div_clk_i(divc), .io_level_i(io_lv), .io_dir_i(~io_lv), .io_level_o(io_o),
		.io_dir_o(io_d), .clock_output_pin_o(clock_output_pin), .clk_en_o(clk_en), .cpu_src_o(cpu_src),
		.cpu_div8_select_o(div8), .main_osc_drive_high_o(drive), .pll_cpu_select_o(pllc),
		.pll_enable_o(plle), .osc_stop_detect_enable_o(oscd), .wake_service_o(svc));
	irq_src_model PARTNER (.clk_i, .rst_n_i, .arm_i(arm), .fire_i(fire), .irq_req_o(req),
		.irq_prio_o(prio), .sub_clk_o(subc), .div_clk_o(divc));

	// clock source
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// port image keeps moving so a frozen pin is visible
	always @(posedge clk_i) io_lv <= rst_n_i ? io_lv + 16'h1 : 16'h0;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	// enter stop by register write or wait by instruction; returns the port image
	task automatic enter(input logic stop, output logic [15:0] held);
		@(posedge clk_i);
		if (stop) begin
			addr <= pwr_mode_pkg::OFS_CLOCK_CONTROL_1;
			wdata <= 32'h1;
			wr <= 1'b1;
		end else begin
			wait_i <= 1'b1;
		end
		#1 held = io_lv;
		@(posedge clk_i);
		wr <= 1'b0;
		wait_i <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	// bounded wait for the cpu clock, noting any service pulse
	task automatic wake(output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 20 && clk_en.cpu_clk_en !== 1'b1; i++) begin
			@(posedge clk_i);
			#1 seen = seen | svc;
		end
	endtask
	task automatic toggles(output logic [31:0] n);
		logic last;
		n = 32'h0;
		last = clock_output_pin;
		repeat (6) begin
			@(posedge clk_i);
			#1 n = n + {31'h0, clock_output_pin ^ last};
			last = clock_output_pin;
		end
	endtask

	task automatic t_regs();
		logic [31:0] rv [6];
		rv = '{32'h2, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 6; i++) begin
			rd_reg(8'(4 * i), rv[i]);
		end
		wr_reg(pwr_mode_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rd_reg(pwr_mode_pkg::OFS_STATUS, 32'h0);
		wr_reg(pwr_mode_pkg::OFS_CLOCK_CONTROL_1, 32'h6);
		wr_reg(pwr_mode_pkg::OFS_PLL_CTRL, 32'h1);
		wr_reg(pwr_mode_pkg::OFS_OSC_DETECT, 32'h1);
		#1 chk({29'h0, pllc, plle, oscd}, 32'h7);
	endtask
	// key wake from wait, after a zero-priority request was ignored
	task automatic t_wait_key();
		logic [15:0] h;
		logic s;
		wr_reg(pwr_mode_pkg::OFS_CLOCK_CONTROL_0, 32'h9);
		enter(1'b0, h);
		chk(32'(clk_en), 32'h9);
		@(posedge clk_i);
		fire <= 9'h004;
		repeat (5) @(posedge clk_i);
		#1 chk(32'(clk_en), 32'h9);
		chk({io_o, io_d}, {h, ~h});
		@(posedge clk_i);
		arm <= 9'h004;
		wake(s);
		chk(32'(clk_en), 32'hF);
		chk(32'(s), 32'h1);
		chk(32'(cpu_src), 32'(pwr_mode_pkg::CLK_SUB));
		rd_reg(pwr_mode_pkg::OFS_STATUS, 32'h20);
	endtask
	// stopped peripheral clocks: sources must not wake, clock pin frozen, nmi wakes
	task automatic t_wait_refuse();
		logic [15:0] h;
		logic [31:0] n;
		logic s;
		wr_reg(pwr_mode_pkg::OFS_CLOCK_CONTROL_0, 32'h5);
		@(posedge clk_i);
		arm <= 9'h0BB;
		fire <= 9'h0BB;
		enter(1'b0, h);
		toggles(n);
		chk(n, 32'h0);
		chk(32'(clk_en), 32'h9);
		@(posedge clk_i);
		nmi_n <= 1'b0;
		wake(s);
		nmi_n <= 1'b1;
		chk(32'(clk_en), 32'hF);
		chk(32'(s), 32'h0);
		rd_reg(pwr_mode_pkg::OFS_STATUS, 32'h10);
		fire <= '0;
		arm <= '0;
	endtask
	// running peripheral clocks: sub clock pin toggles, converter wakes in single mode
	task automatic t_wait_sub();
		logic [15:0] h;
		logic [31:0] n;
		logic s;
		wr_reg(pwr_mode_pkg::OFS_CLOCK_CONTROL_0, 32'h0);
		@(posedge clk_i);
		qual.conv_single <= 1'b1;
		arm <= 9'h008;
		enter(1'b0, h);
		toggles(n);
		chk(n, 32'h6);
		@(posedge clk_i);
		fire <= 9'h008;
		wake(s);
		chk(32'(clk_en), 32'hF);
		fire <= '0;
		qual.conv_single <= 1'b0;
	endtask
	// stop with software preparation, ignored i2c, timer event wake
	task automatic t_stop();
		logic [15:0] h;
		logic s;
		wr_reg(pwr_mode_pkg::OFS_CLOCK_CONTROL_0, 32'h10);
		wr_reg(pwr_mode_pkg::OFS_CLOCK_CONTROL_1, 32'h0);
		wr_reg(pwr_mode_pkg::OFS_PLL_CTRL, 32'h0);
		wr_reg(pwr_mode_pkg::OFS_OSC_DETECT, 32'h0);
		#1 chk({29'h0, pllc, plle, oscd}, 32'h0);
		@(posedge clk_i);
		arm <= 9'h012;
		fire <= 9'h002;
		qual.timer_event_mode <= 1'b1;
		enter(1'b1, h);
		chk(32'(clk_en), 32'h0);
		chk({30'h0, div8, drive}, 32'h3);
		repeat (4) @(posedge clk_i);
		#1 chk(32'(clk_en), 32'h0);
		chk(32'(io_o), 32'(h));
		@(posedge clk_i);
		fire <= 9'h012;
		wake(s);
		chk(32'(clk_en), 32'hF);
		chk(32'(s), 32'h1);
		chk({29'h0, cpu_src, div8}, {29'h0, pwr_mode_pkg::CLK_INTERNAL, 1'b1});
		rd_reg(pwr_mode_pkg::OFS_CLOCK_CONTROL_1, 32'h4);
		fire <= '0;
		arm <= '0;
	endtask
	// hardware reset in mid-wait and in mid-stop brings the clocks straight back
	task automatic t_reset_wake();
		logic [15:0] h;
		for (int m = 0; m < 2; m++) begin
			enter(1'(m), h);
			@(posedge clk_i);
			rst_n_i <= 1'b0;
			#1 chk(32'(clk_en), 32'hF);
			@(posedge clk_i);
			rst_n_i <= 1'b1;
		end
	endtask

	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// watchdog: the run needs well under a thousand cycles
	initial begin
		#40000;
		num_errors++;
		test_done();
	end
	// main sequence
	initial begin
		num_errors = 0;
		checks = 0;
		rst_n_i = 1'b0;
		{wr, rd, wait_i, addr, wdata, arm, fire, qual} = '0;
		iflag = 1'b1;
		nmi_n = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_wait_key();
		t_wait_refuse();
		t_wait_sub();
		t_stop();
		t_reset_wake();
		repeat (4) @(posedge clk_i);
		test_done();
	end
endmodule
